// ==== rtcya_pkg.sv ====
// Shared constants for the year alarm and carry flag block
package rtcya_pkg;
  // Register byte addresses on APB
  localparam logic [11:0] RTCYA_ADDR_YEAR_ALARM   = 12'h000;
  localparam logic [11:0] RTCYA_ADDR_FLAG_CTRL1   = 12'h004;
  localparam logic [11:0] RTCYA_ADDR_CTRL3        = 12'h008;
  localparam logic [11:0] RTCYA_ADDR_MONTH_ALARM  = 12'h00C;
  localparam logic [11:0] RTCYA_ADDR_MATCH_STATUS = 12'h010;

  // Flag control one fields
  localparam int RTCYA_CF_BIT  = 7;
  localparam int RTCYA_CIE_BIT = 4;
  localparam int RTCYA_AIE_BIT = 3;
  localparam int RTCYA_AF_BIT  = 0;

  // Control three field
  localparam int RTCYA_YEAR_ALARM_ENABLE_BIT = 7;

  // Month alarm fields
  localparam int RTCYA_MON_ENB_BIT = 7;
  localparam int RTCYA_MON_TENS_BIT = 4;
  localparam int RTCYA_MON_UNITS_MSB = 3;

  // Widths
  localparam int RTCYA_YEAR_DIGITS = 4;
  localparam int RTCYA_MONTH_DIGITS = 2;
  localparam int RTCYA_YEAR_W = 16;
  localparam int RTCYA_REG8_W = 8;
  localparam int RTCYA_EXT_FIELDS = 5;

  // Reset values
  localparam logic RTCYA_CIE_RST     = 1'b0;
  localparam logic RTCYA_AIE_RST     = 1'b0;
  localparam logic RTCYA_AF_RST      = 1'b0;
  localparam logic RTCYA_YEAR_ALARM_ENABLE_RST    = 1'b0;
  localparam logic RTCYA_MON_ENB_RST = 1'b0;
  localparam logic [31:0] RTCYA_PRDATA_RST = 32'h0000_0000;
endpackage : rtcya_pkg

// ==== rtcya_bcd_cmp.sv ====
// Enable-gated BCD digit comparator for one alarm field
`timescale 1ns/10ps
module rtcya_bcd_cmp #(
  parameter int DIGITS = 4
) (
  input  wire logic [4*DIGITS-1:0] alarm_i,
  input  wire logic [4*DIGITS-1:0] counter_i,
  input  wire logic                enable_i,
  output logic                     match_o
);
  logic [DIGITS-1:0] digit_eq;

  // One equality per BCD digit
  for (genvar g = 0; g < DIGITS; g++) begin : g_digit
    assign digit_eq[g] = (alarm_i[4*g +: 4] == counter_i[4*g +: 4]);
  end

  // Disabled field never blocks the alarm
  assign match_o = ~enable_i | (&digit_eq);
endmodule // rtcya_bcd_cmp

// ==== rtcya_flag.sv ====
// Status flag cell: hardware set, software write, set beats clear
`timescale 1ns/10ps
module rtcya_flag #(
  parameter bit HAS_RESET = 1'b1,
  parameter bit WR1_SETS  = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic hw_set_i,
  input  wire logic wr_en_i,
  input  wire logic wr_val_i,
  output logic      flag_o
);
  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (wr_en_i) begin
      if (!wr_val_i) begin
        flag_d = 1'b0;
      end else if (WR1_SETS) begin
        flag_d = 1'b1;
      end
    end
    // Event in the clearing cycle is kept
    if (hw_set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (HAS_RESET && rst_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule // rtcya_flag

// ==== rtcya_top.sv ====
// Year alarm, alarm match and carry flag logic with APB registers
//
// Summary of operation
// - Year compared with its alarm only while year alarm enable is set.
// - Alarm raised only when all enabled comparisons match together.
// - Year alarm is 16-bit read/write, untouched by any reset or standby.
// - Year alarm holds four BCD digits, thousands in the top nibble.
// - Resets clear flag control one except the carry flag, left undefined.
// - Flag control one keeps its contents across standby.
// - Carry flag set when sub-second or seconds counter counts up.
// - Writing 0 to the carry flag clears it.
// - Writing 1 to the carry flag sets it.
// - Carry during a counter read also sets the carry flag.
// - Each field alarm compared only while its compare enable is set.
// - Alarm match sets alarm flag; write 0 clears, write 1 holds.
// - Alarm interrupt requested only with alarm flag and its enable set.
// - Carry interrupt requested only with carry flag and its enable set.
`timescale 1ns/10ps
module rtcya_top
  import rtcya_pkg::*;
#(
  parameter int EXT_FIELDS = RTCYA_EXT_FIELDS
) (
  input  wire logic                    REF_CLK_I,
  input  wire logic                    SYS_RST_I,
  input  wire logic                    MANUAL_RST_I,
  // APB slave
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [11:0]             PADDR_I,
  input  wire logic [31:0]             PWDATA_I,
  input  wire logic [3:0]              PSTRB_I,
  output logic                         PREADY_O,
  output logic                         PSLVERR_O,
  output logic [31:0]                  PRDATA_O,
  // Clock/calendar side
  input  wire logic                    CAL_UPDATE_I,
  input  wire logic [RTCYA_YEAR_W-1:0] YEAR_COUNTER_I,
  input  wire logic [7:0]              MONTH_COUNTER_I,
  input  wire logic [EXT_FIELDS-1:0]   FIELD_ENABLE_I,
  input  wire logic [EXT_FIELDS-1:0]   FIELD_MATCH_I,
  input  wire logic                    SUBSEC_COUNT_UP_I,
  input  wire logic                    SEC_COUNT_UP_I,
  // Interrupt requests
  output logic                         ALARM_IRQ_O,
  output logic                         CARRY_IRQ_O
);

  // Control state
  logic [RTCYA_YEAR_W-1:0] year_alarm_value_q;
  logic                    year_alarm_enable_q;
  logic                    month_enable_q;
  logic                    month_tens_q;
  logic [3:0]              month_units_q;
  logic                    carry_irq_enable_q;
  logic                    alarm_irq_enable_q;
  logic                    carry_flag;
  logic                    alarm_flag;
  logic [31:0]             prdata_q;

  // Bus decode
  logic        any_rst;
  logic        wr_access;
  logic        rd_setup;
  logic        hit_year;
  logic        hit_ctrl1;
  logic        hit_ctrl3;
  logic        hit_month;
  logic        hit_status;
  logic        addr_mapped;
  logic        wr_year;
  logic        wr_ctrl1;
  logic        wr_ctrl3;
  logic        wr_month;
  logic [31:0] rd_mux;

  // Alarm match
  logic       year_ok;
  logic       month_ok;
  logic       ext_ok;
  logic       any_enabled;
  logic       alarm_match;
  logic       alarm_set;
  logic       carry_set;
  logic [7:0] month_alarm_value;
  logic [7:0] ctrl1_value;

  assign any_rst = SYS_RST_I | MANUAL_RST_I;

  assign hit_year    = (PADDR_I == RTCYA_ADDR_YEAR_ALARM);
  assign hit_ctrl1   = (PADDR_I == RTCYA_ADDR_FLAG_CTRL1);
  assign hit_ctrl3   = (PADDR_I == RTCYA_ADDR_CTRL3);
  assign hit_month   = (PADDR_I == RTCYA_ADDR_MONTH_ALARM);
  assign hit_status  = (PADDR_I == RTCYA_ADDR_MATCH_STATUS);
  assign addr_mapped = hit_year | hit_ctrl1 | hit_ctrl3 | hit_month
                     | hit_status;

  // Zero wait state slave
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_mapped;

  assign wr_access = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_setup  = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign wr_year   = wr_access & hit_year;
  assign wr_ctrl1  = wr_access & hit_ctrl1 & PSTRB_I[0];
  assign wr_ctrl3  = wr_access & hit_ctrl3 & PSTRB_I[0];
  assign wr_month  = wr_access & hit_month & PSTRB_I[0];

  // Year alarm digits, retained through every reset
  always_ff @(posedge REF_CLK_I) begin
    if (wr_year && PSTRB_I[0]) begin
      year_alarm_value_q[7:0] <= PWDATA_I[7:0];
    end
    if (wr_year && PSTRB_I[1]) begin
      year_alarm_value_q[15:8] <= PWDATA_I[15:8];
    end
  end

  // Year alarm enable
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      year_alarm_enable_q <= RTCYA_YEAR_ALARM_ENABLE_RST;
    end else if (wr_ctrl3) begin
      year_alarm_enable_q <= PWDATA_I[RTCYA_YEAR_ALARM_ENABLE_BIT];
    end
  end

  // Month alarm enable, reset at power-on only
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      month_enable_q <= RTCYA_MON_ENB_RST;
    end else if (wr_month) begin
      month_enable_q <= PWDATA_I[RTCYA_MON_ENB_BIT];
    end
  end

  // Month alarm digits, not reset
  always_ff @(posedge REF_CLK_I) begin
    if (wr_month) begin
      month_tens_q  <= PWDATA_I[RTCYA_MON_TENS_BIT];
      month_units_q <= PWDATA_I[RTCYA_MON_UNITS_MSB:0];
    end
  end

  // Interrupt enables; no standby term so contents persist
  always_ff @(posedge REF_CLK_I) begin
    if (any_rst) begin
      carry_irq_enable_q <= RTCYA_CIE_RST;
      alarm_irq_enable_q <= RTCYA_AIE_RST;
    end else if (wr_ctrl1) begin
      carry_irq_enable_q <= PWDATA_I[RTCYA_CIE_BIT];
      alarm_irq_enable_q <= PWDATA_I[RTCYA_AIE_BIT];
    end
  end

  assign month_alarm_value = {month_enable_q, 2'b00, month_tens_q,
                              month_units_q};

  // Field comparisons
  rtcya_bcd_cmp #(
    .DIGITS (RTCYA_YEAR_DIGITS)
  ) u_year_cmp (
    .alarm_i   (year_alarm_value_q),
    .counter_i (YEAR_COUNTER_I),
    .enable_i  (year_alarm_enable_q),
    .match_o   (year_ok)
  );

  rtcya_bcd_cmp #(
    .DIGITS (RTCYA_MONTH_DIGITS)
  ) u_month_cmp (
    .alarm_i   ({3'b000, month_tens_q, month_units_q}),
    .counter_i ({3'b000, MONTH_COUNTER_I[RTCYA_MON_TENS_BIT:0]}),
    .enable_i  (month_enable_q),
    .match_o   (month_ok)
  );

  assign ext_ok      = &(~FIELD_ENABLE_I | FIELD_MATCH_I);
  assign any_enabled = year_alarm_enable_q | month_enable_q
                     | (|FIELD_ENABLE_I);
  assign alarm_match = any_enabled & year_ok & month_ok & ext_ok;
  assign alarm_set   = CAL_UPDATE_I & alarm_match;

  // Alarm flag: write 0 clears, write 1 holds
  rtcya_flag #(
    .HAS_RESET (1'b1),
    .WR1_SETS  (1'b0)
  ) u_alarm_flag (
    .clk_i    (REF_CLK_I),
    .rst_i    (any_rst),
    .hw_set_i (alarm_set),
    .wr_en_i  (wr_ctrl1),
    .wr_val_i (PWDATA_I[RTCYA_AF_BIT]),
    .flag_o   (alarm_flag)
  );

  // Carry flag: no reset, either count-up sets it, read or not
  assign carry_set = SUBSEC_COUNT_UP_I | SEC_COUNT_UP_I;

  rtcya_flag #(
    .HAS_RESET (1'b0),
    .WR1_SETS  (1'b1)
  ) u_carry_flag (
    .clk_i    (REF_CLK_I),
    .rst_i    (any_rst),
    .hw_set_i (carry_set),
    .wr_en_i  (wr_ctrl1),
    .wr_val_i (PWDATA_I[RTCYA_CF_BIT]),
    .flag_o   (carry_flag)
  );

  assign ctrl1_value = {carry_flag, 2'b00, carry_irq_enable_q,
                        alarm_irq_enable_q, 2'b00, alarm_flag};

  // Read multiplexer; reserved and unmapped read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_year:   rd_mux = {16'h0000, year_alarm_value_q};
      hit_ctrl1:  rd_mux = {24'h00_0000, ctrl1_value};
      hit_ctrl3:  rd_mux = {24'h00_0000, year_alarm_enable_q, 7'h00};
      hit_month:  rd_mux = {24'h00_0000, month_alarm_value};
      hit_status: rd_mux = {24'h00_0000, 3'b000, alarm_match,
                            ext_ok, month_ok, year_ok, any_enabled};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      prdata_q <= RTCYA_PRDATA_RST;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end
  end

  assign PRDATA_O = prdata_q;

  assign ALARM_IRQ_O = alarm_flag & alarm_irq_enable_q;
  assign CARRY_IRQ_O = carry_flag & carry_irq_enable_q;

endmodule // rtcya_top

// ==== rtcya_checker.sv ====
// Port assertions for the year alarm block
`timescale 1ns/10ps
module rtcya_checker
  import rtcya_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        SYS_RST_I,
  input wire logic        MANUAL_RST_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic        PSLVERR_O,
  input wire logic [31:0] PRDATA_O,
  input wire logic        CAL_UPDATE_I,
  input wire logic        SUBSEC_COUNT_UP_I,
  input wire logic        SEC_COUNT_UP_I,
  input wire logic        ALARM_IRQ_O,
  input wire logic        CARRY_IRQ_O
);
  logic acc, unm, wfc, cup;
  assign acc = PSEL_I && PENABLE_I;
  assign unm = PADDR_I > 12'h010 || PADDR_I[1:0] != 2'b00;
  assign wfc = acc && PWRITE_I && PADDR_I == RTCYA_ADDR_FLAG_CTRL1;
  assign cup = SUBSEC_COUNT_UP_I || SEC_COUNT_UP_I;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  slverr_map_a: assert property (PSLVERR_O == (acc && unm))
    else $error("pslverr wrong");
  unmapped_read_a: assert property (acc && !PWRITE_I && unm
    |-> PRDATA_O == '0) else $error("unmapped data");
  rdata_hold_a: assert property (!$past(SYS_RST_I) && !$past(PSEL_I
    && !PENABLE_I) |-> $stable(PRDATA_O)) else $error("rdata moved");
  carry_rise_a: assert property ($rose(CARRY_IRQ_O)
    |-> $past(cup || wfc)) else $error("carry irq rose");
  carry_hold_a: assert property (CARRY_IRQ_O && !wfc
    && !MANUAL_RST_I |=> CARRY_IRQ_O) else $error("carry irq lost");
  alarm_rise_a: assert property ($rose(ALARM_IRQ_O)
    |-> $past(CAL_UPDATE_I || wfc)) else $error("alarm irq rose");
  alarm_hold_a: assert property (ALARM_IRQ_O && !wfc
    && !MANUAL_RST_I |=> ALARM_IRQ_O) else $error("alarm irq lost");
  manual_clear_a: assert property (MANUAL_RST_I
    |=> !ALARM_IRQ_O && !CARRY_IRQ_O) else $error("irq after reset");
endmodule // rtcya_checker

// ==== rtcya_top_test.sv ====
// Random and corner-case bench for the year alarm block
`timescale 1ns/10ps
module rtcya_top_test
  import rtcya_pkg::*;
;
  localparam logic [11:0] FC = RTCYA_ADDR_FLAG_CTRL1;
  localparam logic [11:0] YA = RTCYA_ADDR_YEAR_ALARM;
  localparam logic [31:0] CY = 32'h0000_0080;
  logic        REF_CLK_I = 1'b0, SYS_RST_I = 1'b1, MANUAL_RST_I = 1'b0;
  logic        PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0, e;
  logic        CAL_UPDATE_I = 1'b0, SEC_COUNT_UP_I = 1'b0;
  logic        SUBSEC_COUNT_UP_I = 1'b0, PREADY_O, PSLVERR_O;
  logic        ALARM_IRQ_O, CARRY_IRQ_O;
  logic [3:0]  PSTRB_I = 4'hf;
  logic [4:0]  FIELD_ENABLE_I = '0, FIELD_MATCH_I = '0;
  logic [7:0]  MONTH_COUNTER_I = 8'h00;
  logic [11:0] PADDR_I = 12'h000;
  logic [15:0] YEAR_COUNTER_I = 16'h0000, y;
  logic [31:0] PWDATA_I = '0, PRDATA_O, rd, r, sd = 32'h0000_03ba;
  int          bad_count = 0, tests_run = 0;
  always #5 REF_CLK_I = ~REF_CLK_I;
  rtcya_top dut_u (
    .REF_CLK_I         (REF_CLK_I),
    .SYS_RST_I         (SYS_RST_I),
    .MANUAL_RST_I      (MANUAL_RST_I),
    .PSEL_I            (PSEL_I),
    .PENABLE_I         (PENABLE_I),
    .PWRITE_I          (PWRITE_I),
    .PADDR_I           (PADDR_I),
    .PWDATA_I          (PWDATA_I),
    .PSTRB_I           (PSTRB_I),
    .PREADY_O          (PREADY_O),
    .PSLVERR_O         (PSLVERR_O),
    .PRDATA_O          (PRDATA_O),
    .CAL_UPDATE_I      (CAL_UPDATE_I),
    .YEAR_COUNTER_I    (YEAR_COUNTER_I),
    .MONTH_COUNTER_I   (MONTH_COUNTER_I),
    .FIELD_ENABLE_I    (FIELD_ENABLE_I),
    .FIELD_MATCH_I     (FIELD_MATCH_I),
    .SUBSEC_COUNT_UP_I (SUBSEC_COUNT_UP_I),
    .SEC_COUNT_UP_I    (SEC_COUNT_UP_I),
    .ALARM_IRQ_O       (ALARM_IRQ_O),
    .CARRY_IRQ_O       (CARRY_IRQ_O)
  );
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  function automatic logic [15:0] bcd(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      bcd[4*i+:4] = 4'((v >> 8*i) % 10);
  endfunction
  function automatic logic alarm_exp(input logic [31:0] v);
    return (v[0] | v[1] | (|v[8:4])) & (~v[0] | v[2]) & (~v[1] | v[3])
      & !(|(v[8:4] & v[13:9] & v[18:14]));
  endfunction
  // Status bits: match, other fields, month, year, any enabled
  function automatic logic [4:0] stat_exp(input logic [31:0] v);
    return {alarm_exp(v), !(|(v[8:4] & v[13:9] & v[18:14])),
      ~v[1] | v[3], ~v[0] | v[2], v[0] | v[1] | (|v[8:4])};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge REF_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge REF_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge REF_CLK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, x);
    tests_run++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, x);
    apb(1'b0, a, '0);
    chk(rd & m, x);
  endtask
  task automatic tick(input logic [2:0] s);
    @(posedge REF_CLK_I);
    {CAL_UPDATE_I, SEC_COUNT_UP_I, SUBSEC_COUNT_UP_I} <= s;
    @(posedge REF_CLK_I);
    {CAL_UPDATE_I, SEC_COUNT_UP_I, SUBSEC_COUNT_UP_I} <= 3'b000;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #50000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge REF_CLK_I);
    SYS_RST_I <= 1'b0;
    rc(FC, 32'h0000_007f, '0);
    rc(12'h0fc, '1, '0);
    apb(1'b1, FC, 32'h0000_0090);
    rc(FC, CY, CY);
    chk(CARRY_IRQ_O, 1'b1);
    for (int i = 1; i < 3; i++) begin
      apb(1'b1, FC, 32'h0000_0010);
      rc(FC, CY, '0);
      tick(3'(i));
      rc(FC, CY, CY);
    end
    apb(1'b1, FC, 32'h0000_0080);
    rc(FC, CY, CY);
    chk(CARRY_IRQ_O, 1'b0);
    $display("carry test done");
    for (int k = 0; k < 4; k++) begin
      y = k ? bcd(rnd()) : 16'h9999;
      apb(1'b1, YA, {16'h0000, y});
      apb(1'b1, FC, 32'h0000_0018);
      MANUAL_RST_I <= 1'b1;
      @(posedge REF_CLK_I);
      MANUAL_RST_I <= 1'b0;
      rc(FC, 32'h0000_007f, '0);
      rc(YA, 32'h0000_ffff, {16'h0000, y});
    end
    // Low lane only: upper digits must survive
    PSTRB_I <= 4'h1;
    apb(1'b1, YA, 32'h0000_0000);
    PSTRB_I <= 4'hf;
    y = {y[15:8], 8'h00};
    rc(YA, 32'h0000_ffff, {16'h0000, y});
    $display("year test done");
    apb(1'b1, FC, 32'h0000_0008);
    repeat (24) begin
      r = rnd();
      e = alarm_exp(r);
      apb(1'b1, RTCYA_ADDR_CTRL3, {24'h00_0000, r[0], 7'h00});
      apb(1'b1, RTCYA_ADDR_MONTH_ALARM, {24'h00_0000, r[1], 7'h12});
      YEAR_COUNTER_I <= r[2] ? y : y ^ 16'h0001;
      MONTH_COUNTER_I <= r[3] ? 8'h12 : 8'h11;
      FIELD_ENABLE_I <= r[8:4];
      FIELD_MATCH_I <= ~(r[8:4] & r[13:9] & r[18:14]);
      tick(3'b100);
      rc(RTCYA_ADDR_MONTH_ALARM, 32'h0000_00ff,
         {24'h00_0000, r[1], 7'h12});
      rc(RTCYA_ADDR_MATCH_STATUS, 32'h0000_001f,
         32'(stat_exp(r)));
      rc(FC, 32'h0000_0001, 32'(e));
      chk(ALARM_IRQ_O, e);
      apb(1'b1, FC, 32'h0000_0009);
      rc(FC, 32'h0000_0001, 32'(e));
      apb(1'b1, FC, 32'h0000_0008);
      rc(FC, 32'h0000_0001, '0);
    end
    $display("alarm test done");
    wrap_up();
  end
endmodule // rtcya_top_test
bind rtcya_top rtcya_checker chk_u (
  .REF_CLK_I         (REF_CLK_I),
  .SYS_RST_I         (SYS_RST_I),
  .MANUAL_RST_I      (MANUAL_RST_I),
  .PSEL_I            (PSEL_I),
  .PENABLE_I         (PENABLE_I),
  .PWRITE_I          (PWRITE_I),
  .PADDR_I           (PADDR_I),
  .PSLVERR_O         (PSLVERR_O),
  .PRDATA_O          (PRDATA_O),
  .CAL_UPDATE_I      (CAL_UPDATE_I),
  .SUBSEC_COUNT_UP_I (SUBSEC_COUNT_UP_I),
  .SEC_COUNT_UP_I    (SEC_COUNT_UP_I),
  .ALARM_IRQ_O       (ALARM_IRQ_O),
  .CARRY_IRQ_O       (CARRY_IRQ_O)
);
